//--- hdl/tcc_timer.sv
// Purpose: Eight-bit timer/counter with overflow flag and shared prescaler.
// Assumes: Register port strobes are one cycle; read data stand one cycle later.
// Notes: The prescaler serves either this counter or the watchdog tick path.
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module tcc_timer (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic shared_count_pin_i,
   input wire logic sleep_i,
   input wire logic wdt_tick_i,
   input wire logic wdt_clear_i,
   output logic wdt_tick_o,
   output logic instr_tick_o,
   output logic [7:0] count_register_o,
   output logic ovf_request_o,
   output logic irq_o
);

   // ****************************************************************
   // State
   // ****************************************************************

   typedef struct packed {
      logic [1:0] phase;
      logic [7:0] count_register;
      logic [7:0] option;
      logic [7:0] interrupt_control;
      logic [1:0] inhibit;
      logic status_ovf;
      logic mask_ovf;
      logic [7:0] rdata;
      logic assign_q;
      logic edge_level_q;
   } tcc_state_t;

   tcc_state_t state;
   tcc_state_t next_state;

   tcc_psc_if psc_bus ();

   logic second_phase;
   logic fourth_phase;
   logic instr_tick;
   logic clock_source_select;
   logic source_edge_select;
   logic prescaler_assign_bit;
   logic psc_to_timer;
   logic edge_level;
   logic edge_rise;
   logic sync_level;
   logic sync_rise;
   logic count_write;
   logic count_step;
   logic overflow;
   logic wr_count;
   logic wr_option;
   logic wr_intctl;
   logic wr_status;
   logic wr_mask;

   // ****************************************************************
   // Phase generation
   // ****************************************************************

   // Four clocks make one instruction cycle; phase strobes mark its second and fourth clock.
   assign second_phase = (state.phase == tcc_pkg::PHASE_SECOND);
   assign fourth_phase = (state.phase == tcc_pkg::PHASE_FOURTH);
   assign instr_tick = (state.phase == tcc_pkg::PHASE_LAST);

   // ****************************************************************
   // Option decode
   // ****************************************************************

   // Fields of the option register that steer the counter.
   assign clock_source_select = state.option[tcc_pkg::OPT_SRC_BIT];
   assign source_edge_select = state.option[tcc_pkg::OPT_EDGE_BIT];
   assign prescaler_assign_bit = state.option[tcc_pkg::OPT_ASSIGN_BIT];
   assign psc_to_timer = !prescaler_assign_bit;

   // ****************************************************************
   // Register port decode
   // ****************************************************************

   // One write strobe per register.
   assign wr_count = wr_i && (addr_i == tcc_pkg::OFS_COUNT);
   assign wr_option = wr_i && (addr_i == tcc_pkg::OFS_OPTION);
   assign wr_intctl = wr_i && (addr_i == tcc_pkg::OFS_INTCTL);
   assign wr_status = wr_i && (addr_i == tcc_pkg::OFS_STATUS);
   assign wr_mask = wr_i && (addr_i == tcc_pkg::OFS_MASK);
   assign count_write = wr_count;

   // ****************************************************************
   // External count path
   // ****************************************************************

   // Inverting the pin on a set edge select turns falling edges into rises.
   assign edge_level = shared_count_pin_i ^ source_edge_select;
   assign edge_rise = edge_level && !state.edge_level_q;

   // The synchroniser sees the prescaler output, or the edge-selected pin level without one.
   assign sync_level = psc_to_timer ? psc_bus.level : edge_level;

   tcc_phase_sync u_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .level_i(sync_level),
      .second_phase_i(second_phase),
      .fourth_phase_i(fourth_phase),
      .rise_o(sync_rise)
   );

   // ****************************************************************
   // Shared prescaler
   // ****************************************************************

   // The prescaler takes events only from the party it is assigned to.
   always_comb begin
      if (prescaler_assign_bit) begin
         psc_bus.event_in = wdt_tick_i;
      end else if (sleep_i) begin
         psc_bus.event_in = 1'b0;
      end else if (clock_source_select) begin
         psc_bus.event_in = edge_rise;
      end else begin
         psc_bus.event_in = instr_tick;
      end
   end

   // Clear on a count write while assigned here, on a watchdog clear while the watchdog owns it, or on reassignment.
   assign psc_bus.clear = (count_write && psc_to_timer)
      || (wdt_clear_i && prescaler_assign_bit)
      || (prescaler_assign_bit != state.assign_q);
   assign psc_bus.rate = state.option[tcc_pkg::OPT_RATE_LSB +: tcc_pkg::RATE_W];

   tcc_prescaler u_psc (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .psc(psc_bus.psc)
   );

   // The watchdog gets the divided tick only while it owns the prescaler.
   assign wdt_tick_o = prescaler_assign_bit ? psc_bus.tick : wdt_tick_i;

   // ****************************************************************
   // Count step
   // ****************************************************************

   // Pick the increment source, then gate it by sleep and the write inhibit.
   always_comb begin
      count_step = 1'b0;
      if (clock_source_select) begin
         count_step = sync_rise;
      end else if (psc_to_timer) begin
         count_step = psc_bus.tick;
      end else begin
         count_step = instr_tick;
      end
      if (sleep_i || (state.inhibit != 2'h0) || count_write) begin
         count_step = 1'b0;
      end
   end

   // An overflow is a step taken from the top value.
   assign overflow = count_step && (state.count_register == tcc_pkg::COUNT_MAX);

   // ****************************************************************
   // Next state
   // ****************************************************************

   // Registers, counter, flags and read data.
   always_comb begin
      next_state = state;
      next_state.phase = state.phase + 2'h1;
      next_state.assign_q = prescaler_assign_bit;
      next_state.edge_level_q = edge_level;

      // Inhibit countdown runs one step per instruction cycle.
      if (instr_tick && (state.inhibit != 2'h0)) begin
         next_state.inhibit = state.inhibit - 2'h1;
      end

      // Counter update; a software write wins over a step.
      if (count_write) begin
         next_state.count_register = wdata_i;
         next_state.inhibit = tcc_pkg::INHIBIT_CYCLES;
      end else if (count_step) begin
         next_state.count_register = state.count_register + 8'h01;
      end

      // Option register writes.
      if (wr_option) begin
         next_state.option = wdata_i;
      end

      // Control register writes; software clears the flag by writing a zero.
      if (wr_intctl) begin
         next_state.interrupt_control = wdata_i;
      end
      if (overflow) begin
         next_state.interrupt_control[tcc_pkg::ICTL_FLAG_BIT] = 1'b1;
      end

      // Sticky status, write one to clear; a new event wins over the clear.
      if (wr_status && wdata_i[tcc_pkg::STAT_OVF_BIT]) begin
         next_state.status_ovf = 1'b0;
      end
      if (overflow) begin
         next_state.status_ovf = 1'b1;
      end
      if (wr_mask) begin
         next_state.mask_ovf = wdata_i[tcc_pkg::STAT_OVF_BIT];
      end

      // Read data stand in the cycle after the strobe; unmapped reads give zero.
      next_state.rdata = 8'h00;
      if (rd_i) begin
         case (addr_i)
            tcc_pkg::OFS_COUNT: begin
               next_state.rdata = state.count_register;
            end
            tcc_pkg::OFS_OPTION: begin
               next_state.rdata = state.option;
            end
            tcc_pkg::OFS_INTCTL: begin
               next_state.rdata = state.interrupt_control;
            end
            tcc_pkg::OFS_STATUS: begin
               next_state.rdata[tcc_pkg::STAT_OVF_BIT] = state.status_ovf;
            end
            tcc_pkg::OFS_MASK: begin
               next_state.rdata[tcc_pkg::STAT_OVF_BIT] = state.mask_ovf;
            end
            default: begin
               next_state.rdata = 8'h00;
            end
         endcase
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************

   // Synchronous reset to documented values.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state.phase <= 2'h0;
         state.count_register <= tcc_pkg::RST_COUNT;
         state.option <= tcc_pkg::RST_OPTION;
         state.interrupt_control <= tcc_pkg::RST_INTCTL;
         state.inhibit <= 2'h0;
         state.status_ovf <= 1'b0;
         state.mask_ovf <= 1'b0;
         state.rdata <= 8'h00;
         state.assign_q <= 1'b1;
         state.edge_level_q <= 1'b1; // Idle low pin under the reset edge select, so no false edge.
      end else begin
         state <= next_state;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   // Request follows flag and enable; the flag itself is untouched by the enable.
   assign ovf_request_o = state.interrupt_control[tcc_pkg::ICTL_FLAG_BIT]
      && state.interrupt_control[tcc_pkg::ICTL_ENABLE_BIT];
   assign irq_o = state.status_ovf && state.mask_ovf;
   assign rdata_o = state.rdata;
   assign count_register_o = state.count_register;
   assign instr_tick_o = instr_tick;

endmodule // tcc_timer

`default_nettype wire

//--- inc/tcc_pkg.sv
// Purpose: Constants for the eight-bit timer/counter with shared prescaler.
// Assumes: One 100 MHz clock; an instruction cycle is four clocks (phases one to four).
// Notes: Register offsets, option and control fields, reset values and counts live here.
// What this block does
// - Source select clear: count instruction cycles.
// - Timer, no prescaler: add one per cycle.
// - Count write inhibits counting two instruction cycles.
// - Source select set: count external pin edges.
// - Edge select: clear rising, set falling.
// - Wrap from FF to 00 sets flag.
// - Enable bit masks request, not the flag.
// - Flag stays set until software clears.
// - Sleep halts the timer, no overflow.
// - One prescaler, timer or watchdog, hidden.
// - External path sampled on phases two, four.
// - Assign bit plus three-bit rate field.
// - Count write clears prescaler when assigned.

package tcc_pkg;

   // Register offsets on the plain register port.
   localparam logic [7:0] OFS_COUNT = 8'h01;
   localparam logic [7:0] OFS_OPTION = 8'h02;
   localparam logic [7:0] OFS_INTCTL = 8'h0B;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_MASK = 8'h0D;

   // Option register fields.
   localparam int OPT_SRC_BIT = 5;
   localparam int OPT_EDGE_BIT = 4;
   localparam int OPT_ASSIGN_BIT = 3;
   localparam int OPT_RATE_LSB = 0;
   localparam int RATE_W = 3;

   // Interrupt control register fields.
   localparam int ICTL_ENABLE_BIT = 5;
   localparam int ICTL_FLAG_BIT = 2;

   // Status and mask register field.
   localparam int STAT_OVF_BIT = 0;

   // Reset values.
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_OPTION = 8'hFF;
   localparam logic [7:0] RST_INTCTL = 8'h00;

   // Instruction cycle phases and the inhibit count after a count write.
   localparam logic [1:0] PHASE_LAST = 2'h3;
   localparam logic [1:0] PHASE_SECOND = 2'h1;
   localparam logic [1:0] PHASE_FOURTH = 2'h3;
   localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

   // Count limits.
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam int PSC_W = 8;

endpackage

//--- inc/tcc_psc_if.sv
// Purpose: Carrier between the timer core and its shared prescaler.
// Assumes: All signals belong to clk_i.
// Notes: The core drives event, clear and rate; the prescaler answers with level and tick.
`timescale 1ns/100ps
`default_nettype none

interface tcc_psc_if;
   logic event_in;
   logic clear;
   logic [tcc_pkg::RATE_W-1:0] rate;
   logic level;
   logic tick;

   modport core (output event_in, output clear, output rate, input level, input tick);
   modport psc (input event_in, input clear, input rate, output level, output tick);
endinterface

`default_nettype wire

//--- hdl/tcc_prescaler.sv
// Purpose: Shared eight-bit prescaler, divide by two to the rate plus one.
// Assumes: Events are one-cycle pulses on clk_i.
// Notes: Its count is never visible to software.
`timescale 1ns/100ps
`default_nettype none

module tcc_prescaler (
   input wire logic clk_i,
   input wire logic reset_i,
   tcc_psc_if.psc psc
);

   typedef struct packed {
      logic [tcc_pkg::PSC_W-1:0] count;
   } tcc_psc_state_t;

   tcc_psc_state_t state;
   tcc_psc_state_t next_state;
   logic [tcc_pkg::PSC_W-1:0] top_mask;

   // ****************************************************************
   // Division
   // ****************************************************************

   // Mask of the low rate+1 bits; a full mask ends one output period.
   assign top_mask = tcc_pkg::PSC_W'((9'h002 << psc.rate) - 9'h001);
   assign psc.level = state.count[psc.rate];
   assign psc.tick = psc.event_in && ((state.count & top_mask) == top_mask);

   // Next count: a clear wins over an event.
   always_comb begin
      next_state = state;
      if (psc.clear) begin
         next_state.count = '0;
      end else if (psc.event_in) begin
         next_state.count = state.count + 8'h01;
      end
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

endmodule // tcc_prescaler

`default_nettype wire

//--- hdl/tcc_phase_sync.sv
// Purpose: Samples the external count level on phases two and four and finds rises.
// Assumes: Phase strobes are one-cycle pulses from the core.
// Notes: The first stage feeds the second stage only.
`timescale 1ns/100ps
`default_nettype none

module tcc_phase_sync (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic level_i,
   input wire logic second_phase_i,
   input wire logic fourth_phase_i,
   output logic rise_o
);

   typedef struct packed {
      logic stage_a;
      logic stage_b;
      logic prev;
   } tcc_sync_state_t;

   tcc_sync_state_t state;
   tcc_sync_state_t next_state;

   // A rise is seen at the fourth phase, aligned with the instruction tick.
   assign rise_o = fourth_phase_i && state.stage_b && !state.prev;

   // Stage A samples on phase two, stage B on phase four.
   always_comb begin
      next_state = state;
      if (second_phase_i) begin
         next_state.stage_a = level_i;
      end
      if (fourth_phase_i) begin
         next_state.stage_b = state.stage_a;
         next_state.prev = state.stage_b;
      end
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

endmodule // tcc_phase_sync

`default_nettype wire

//--- dv/tcc_timer_asserts.sv
// Purpose: Port-level checks for the timer/counter.
// Assumes: Mirrors follow option, control and count writes.
// Notes: Bound to every tcc_timer instance.
`timescale 1ns/100ps
`default_nettype none

module tcc_timer_asserts (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic sleep_i,
   input wire logic wdt_tick_i,
   input wire logic wdt_tick_o,
   input wire logic instr_tick_o,
   input wire logic [7:0] count_register_o,
   input wire logic ovf_request_o
);
   logic [7:0] opt;
   logic ien;
   logic [1:0] inh;
   logic wc;
   // Count writes restart the two-tick hold-off.
   assign wc = wr_i && addr_i == tcc_pkg::OFS_COUNT;
   // Mirrors option, enable and the remaining hold-off.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         opt <= tcc_pkg::RST_OPTION;
         ien <= 1'b0;
         inh <= 2'h0;
      end else begin
         if (wr_i && addr_i == tcc_pkg::OFS_OPTION) begin
            opt <= wdata_i;
         end
         if (wr_i && addr_i == tcc_pkg::OFS_INTCTL) begin
            ien <= wdata_i[tcc_pkg::ICTL_ENABLE_BIT];
         end
         if (wc) begin
            inh <= tcc_pkg::INHIBIT_CYCLES;
         end else if (instr_tick_o && inh != 2'h0) begin
            inh <= inh - 2'h1;
         end
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   a_tick_spacing: assert property (
      instr_tick_o |=> !instr_tick_o [*3] ##1 instr_tick_o) else $error("tick spacing wrong");
   a_step_on_tick: assert property (
      !instr_tick_o && !wc |=> $stable(count_register_o)) else $error("count moved off tick");
   a_timer_step: assert property (
      instr_tick_o && !wc && !sleep_i && !opt[5] && opt[3] && inh == 2'h0
      |=> count_register_o == $past(count_register_o) + 8'h01) else $error("timer missed step");
   a_write_holdoff: assert property (
      instr_tick_o && inh != 2'h0 && !wc |=> $stable(count_register_o))
      else $error("count moved in hold-off");
   a_sleep_hold: assert property (
      sleep_i && !wc |=> $stable(count_register_o)) else $error("count moved in sleep");
   a_wrap_flag: assert property (
      count_register_o == 8'hFF && !wr_i ##1 count_register_o == 8'h00 && !wr_i && ien
      |=> ovf_request_o) else $error("wrap left no request");
   a_req_masked: assert property (
      ovf_request_o |-> ien) else $error("request while disabled");
   a_flag_sticky: assert property (
      ovf_request_o && !wr_i |=> ovf_request_o) else $error("request dropped alone");
   a_read_count: assert property (
      rd_i && addr_i == tcc_pkg::OFS_COUNT |=> rdata_o == $past(count_register_o))
      else $error("count read wrong");
   a_read_idle: assert property (
      !rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
   a_wdt_bypass: assert property (
      !opt[3] |-> wdt_tick_o == wdt_tick_i) else $error("watchdog tick not bypassed");
endmodule // tcc_timer_asserts

bind tcc_timer tcc_timer_asserts chk_u (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i,
   .rd_i, .rdata_o, .sleep_i, .wdt_tick_i, .wdt_tick_o, .instr_tick_o,
   .count_register_o, .ovf_request_o);

`default_nettype wire

//--- dv/tcc_pin_src.sv
// Purpose: External count source toggling the shared count pin.
// Assumes: Runs on the bench clock.
// Notes: Between bursts the pin holds its last level.
`timescale 1ns/100ps
`default_nettype none

module tcc_pin_src (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic [7:0] edges_i,
   input wire logic [7:0] hold_i,
   output logic pin_o,
   output logic busy_o
);
   logic [7:0] left;
   logic [7:0] cnt;
   // Each level stands hold_i + 1 clocks so both phase samples see it.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pin_o <= 1'b0;
         left <= 8'h00;
         cnt <= 8'h00;
      end else if (start_i) begin
         left <= edges_i;
         cnt <= hold_i;
      end else if (left != 8'h00) begin
         if (cnt == 8'h00) begin
            pin_o <= !pin_o;
            left <= left - 8'h01;
            cnt <= hold_i;
         end else begin
            cnt <= cnt - 8'h01;
         end
      end
   end
   assign busy_o = left != 8'h00;
endmodule // tcc_pin_src

`default_nettype wire

//--- dv/tcc_timer_test.sv
// Purpose: Self-checking bench for the timer/counter.
// Assumes: Drives on rising edges, samples on falling edges.
// Notes: Random values come from a fixed seed.
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end

module tcc_timer_test;
   logic clk_i, reset_i, wr_i, rd_i, sleep_i, wdt_tick_i, wdt_clear_i;
   logic [7:0] addr_i, wdata_i, rdata_o, count_register_o, edges, hold, v, d;
   logic pin, busy, start, s, wdt_tick_o, instr_tick_o, ovf_request_o, irq_o;
   int errors, checked, n, r, k;
   integer seed;

   tcc_timer dut_u (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .shared_count_pin_i(pin), .sleep_i, .wdt_tick_i, .wdt_clear_i, .wdt_tick_o,
      .instr_tick_o, .count_register_o, .ovf_request_o, .irq_o);
   tcc_pin_src src_u (.clk_i, .reset_i, .start_i(start), .edges_i(edges),
      .hold_i(hold), .pin_o(pin), .busy_o(busy));

   // 100 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // ****
   // Register port and expectation helpers.
   // ****
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= x;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      `CHK(rdata_o, e)
   endtask

   task automatic ticks(input int t);
      int c;
      c = 0;
      while (c < t) begin
         @(negedge clk_i);
         if (instr_tick_o === 1'b1) c++;
      end
   endtask

   // Selected edges in t toggles from start level l.
   function automatic logic [7:0] edges_of(logic l, int t, logic fall);
      return (l ^ fall) ? 8'(t / 2) : 8'(t - t / 2);
   endfunction

   // Prescale ratio is two to the rate plus one.
   function automatic int ratio(int q);
      return 2 << q;
   endfunction

   task automatic report_and_stop;
      if (errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Cuts a hang short.
   initial begin
      repeat (40000) @(posedge clk_i);
      errors++;
      report_and_stop();
   end

   // Main sequence.
   initial begin
      seed = 51;
      errors = 0;
      checked = 0;
      reset_i = 1'b1;
      {wr_i, rd_i, sleep_i, wdt_tick_i, wdt_clear_i, start} = 6'h00;
      {addr_i, wdata_i, edges, hold} = 32'h0000_0000;
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      rc(tcc_pkg::OFS_COUNT, tcc_pkg::RST_COUNT);
      rc(tcc_pkg::OFS_OPTION, tcc_pkg::RST_OPTION);
      rc(tcc_pkg::OFS_INTCTL, tcc_pkg::RST_INTCTL);
      wr(8'h30, 8'h5A);
      rc(8'h30, 8'h00);
      wr(tcc_pkg::OFS_OPTION, 8'h08);
      repeat (4) begin
         v = 8'($random(seed));
         n = 2 + ($random(seed) & 15);
         wr(tcc_pkg::OFS_COUNT, v);
         ticks(n);
         rc(tcc_pkg::OFS_COUNT, 8'(v + n - 2));
      end
      for (r = 0; r < 8; r++) begin
         wr(tcc_pkg::OFS_OPTION, 8'(r));
         v = 8'($random(seed));
         wr(tcc_pkg::OFS_COUNT, v);
         ticks(2 * ratio(r) + 2);
         rc(tcc_pkg::OFS_COUNT, 8'(v + 2));
      end
      for (k = 0; k < 4; k++) begin
         d = {2'b00, 1'b1, k[0], !k[1], 3'b000};
         wr(tcc_pkg::OFS_OPTION, d);
         ticks(3);
         v = 8'($random(seed));
         wr(tcc_pkg::OFS_COUNT, v);
         ticks(3);
         edges = 8'(1 + ($random(seed) & 7));
         hold = 8'(4 + ($random(seed) & 7));
         s = pin;
         @(posedge clk_i);
         start <= 1'b1;
         @(posedge clk_i);
         start <= 1'b0;
         do @(negedge clk_i); while (busy);
         repeat (20) @(posedge clk_i);
         n = edges_of(s, edges, k[0]);
         rc(tcc_pkg::OFS_COUNT, 8'(v + (k[1] ? (n + 1) / 2 : n)));
      end
      wr(tcc_pkg::OFS_OPTION, 8'h08);
      wr(tcc_pkg::OFS_INTCTL, 8'h00);
      wr(tcc_pkg::OFS_STATUS, 8'h01);
      wr(tcc_pkg::OFS_COUNT, 8'hFD);
      ticks(5);
      rc(tcc_pkg::OFS_INTCTL, 8'h04);
      `CHK(ovf_request_o, 1'b0)
      rc(tcc_pkg::OFS_STATUS, 8'h01);
      `CHK(irq_o, 1'b0)
      wr(tcc_pkg::OFS_MASK, 8'h01);
      @(negedge clk_i);
      `CHK(irq_o, 1'b1)
      wr(tcc_pkg::OFS_INTCTL, 8'h00);
      wr(tcc_pkg::OFS_INTCTL, 8'h20);
      wr(tcc_pkg::OFS_COUNT, 8'hFD);
      ticks(5);
      @(negedge clk_i);
      `CHK(ovf_request_o, 1'b1)
      ticks(8);
      `CHK(ovf_request_o, 1'b1)
      wr(tcc_pkg::OFS_INTCTL, 8'h20);
      @(negedge clk_i);
      `CHK(ovf_request_o, 1'b0)
      wr(tcc_pkg::OFS_STATUS, 8'h01);
      @(negedge clk_i);
      `CHK(irq_o, 1'b0)
      wr(tcc_pkg::OFS_COUNT, 8'hFE);
      ticks(3);
      @(posedge clk_i);
      sleep_i <= 1'b1;
      ticks(12);
      rc(tcc_pkg::OFS_COUNT, 8'hFF);
      rc(tcc_pkg::OFS_INTCTL, 8'h20);
      @(posedge clk_i);
      sleep_i <= 1'b0;
      ticks(2);
      rc(tcc_pkg::OFS_INTCTL, 8'h24);
      wr(tcc_pkg::OFS_OPTION, 8'h09);
      @(posedge clk_i);
      wdt_clear_i <= 1'b1;
      @(posedge clk_i);
      wdt_clear_i <= 1'b0;
      n = 0;
      repeat (18) begin
         @(posedge clk_i);
         wdt_tick_i <= ~wdt_tick_i & (n < 99);
         @(negedge clk_i);
         if (wdt_tick_o === 1'b1) n++;
      end
      `CHK(n, 2)
      report_and_stop();
   end
endmodule // tcc_timer_test

`default_nettype wire
